// *** shared/tsc_pkg.sv ***
`default_nettype none
package tsc_pkg;
    // APB byte offsets
    localparam logic [7:0] TSC_OFS_TEMP   = 8'h00;
    localparam logic [7:0] TSC_OFS_CFG    = 8'h04;
    localparam logic [7:0] TSC_OFS_HYST   = 8'h08;
    localparam logic [7:0] TSC_OFS_OVT    = 8'h0c;
    localparam logic [7:0] TSC_OFS_RAW    = 8'h10;
    localparam logic [7:0] TSC_OFS_IRQST  = 8'h14;
    localparam logic [7:0] TSC_OFS_IRQMSK = 8'h18;
    // Configuration field positions
    localparam int TSC_CFG_SHDN   = 0;
    localparam int TSC_CFG_INTMD  = 1;
    localparam int TSC_CFG_POL    = 2;
    localparam int TSC_CFG_FQ_LO  = 3;
    localparam int TSC_CFG_FQ_HI  = 4;
    localparam int TSC_CFG_FMT    = 5;
    localparam int TSC_CFG_TODIS  = 6;
    localparam int TSC_CFG_ONESH  = 7;
    // Interrupt status bit positions
    localparam int TSC_IRQ_CONV   = 0;
    localparam int TSC_IRQ_ALARM  = 1;
    localparam int TSC_IRQ_TOUT   = 2;
    // Reset values
    localparam logic [7:0]  TSC_CFG_RST_NOPIN = 8'h00;
    localparam logic [7:0]  TSC_CFG_RST_PIN   = 8'h40;
    localparam logic [15:0] TSC_HYST_RST      = 16'h4b00;
    localparam logic [15:0] TSC_OVT_RST       = 16'h5000;
    localparam logic [15:0] TSC_TEMP_RST      = 16'h0000;
    // Extended format offset of 64 degrees in 1/256 units
    localparam logic [15:0] TSC_EXT_OFS       = 16'h4000;
    // Timing
    localparam int TSC_CLK_MHZ      = 100;
    localparam int TSC_TOUT_MS      = 50;
    localparam int TSC_TOUT_CYC     = TSC_TOUT_MS * 1000 * 1000 / 1000 * TSC_CLK_MHZ;
    localparam int TSC_CONV_CYC_DEF = 64;
    // Fault counts per queue code
    localparam logic [2:0] TSC_FQ_N0 = 3'h1;
    localparam logic [2:0] TSC_FQ_N1 = 3'h2;
    localparam logic [2:0] TSC_FQ_N2 = 3'h4;
    localparam logic [2:0] TSC_FQ_N3 = 3'h6;
endpackage : tsc_pkg
`default_nettype wire

// *** rtl/tsc_sync.sv ***
`default_nettype none
module tsc_sync
    import tsc_pkg::*;
(
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic clk_en,
    // Asynchronous level in, synchronous level out
    input  wire logic din,
    output logic      dout
);
    logic meta_r;
    logic meta_nxt;
    logic sync_r;
    logic sync_nxt;

    // Two stage chain; only the second stage is visible
    always_comb begin
        meta_nxt = clk_en ? din : meta_r;
        sync_nxt = clk_en ? meta_r : sync_r;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign dout = sync_r;
endmodule : tsc_sync
`default_nettype wire

// *** rtl/tsc_fault_queue.sv ***
`default_nettype none
module tsc_fault_queue
    import tsc_pkg::*;
(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       clk_en,
    // Conversion results
    input  wire logic       conv_done,
    input  wire logic       fault,
    input  wire logic [1:0] fq_code,
    // Trip when enough consecutive faults seen
    output logic            tripped
);
    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;
    logic [2:0] need;

    // Decode fault count; restart on a clean conversion or after a trip
    always_comb begin
        unique case (fq_code)
            2'b00: need = TSC_FQ_N0;
            2'b01: need = TSC_FQ_N1;
            2'b10: need = TSC_FQ_N2;
            2'b11: need = TSC_FQ_N3;
        endcase
        cnt_nxt = cnt_r;
        if (clk_en && conv_done) begin
            if (!fault || tripped)
                cnt_nxt = 3'h0;
            else if (cnt_r < need)
                cnt_nxt = cnt_r + 3'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cnt_r <= 3'h0;
        else
            cnt_r <= cnt_nxt;
    end

    // The finishing conversion counts too, so the n-th fault in a row trips
    assign tripped = fault && (cnt_r + 3'h1 >= need);
endmodule : tsc_fault_queue
`default_nettype wire

// *** rtl/tsc_config_ctrl.sv ***
// Overview of operation
// - Fault queue code 00,01,10,11 demands 1,2,4,6 faults.
// - Format bit set selects the extended format for result and thresholds.
// - Extended format reports code equal to temperature minus 64 degrees.
// - Format change takes effect only after the next conversion completes.
// - Timeout disable bit set turns off bus timeout detection.
// - With timeout enabled, data held low beyond 50 ms resets interface.
// - One-shot in shutdown starts one conversion, then back to shutdown.
// - One-shot bit clears itself when the triggered conversion completes.
// - One-shot written outside shutdown is ignored.
// - Reset defaults: comparator, active-low, one fault, normal, variant timeout.
// - Reset input low restores interface and all registers to defaults.
// - Alarm trips only after configured consecutive faults; clean conversion restarts.
// - Shutdown bit waits for conversion end; clearing starts a conversion.
// - Mode bit selects comparator or latched interrupt alarm behaviour.
// - Polarity bit: 0 active-low alarm, 1 active-high alarm.
//
// The APB register port and the register offsets were left to the implementer.
`default_nettype none
module tsc_config_ctrl
    import tsc_pkg::*;
#(
    parameter bit HAS_RESET_PIN = 1'b1,
    parameter int TOUT_CYC      = TSC_TOUT_CYC,
    parameter int CONV_CYC      = TSC_CONV_CYC_DEF
)(
    // Clock, reset, enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Converter interface
    input  wire logic [15:0] adc_temp,
    input  wire logic        adc_done,
    output logic             adc_start,
    // Serial bus data line, seen from outside
    input  wire logic        sda_in,
    output logic             bus_if_reset,
    // Alarm pin, open drain: oe low pulls low
    output logic             overtemp_alarm_output,
    output logic             overtemp_alarm_oe_n,
    // Interrupt
    output logic             irq
);
    initial begin
        if (TOUT_CYC < 1 || CONV_CYC < 1)
            $error("tsc_config_ctrl: counts must be positive");
    end

    localparam logic [7:0] CFG_RST = HAS_RESET_PIN ? TSC_CFG_RST_PIN : TSC_CFG_RST_NOPIN;

    // Register state
    logic [7:0]  cfg_r,     cfg_nxt;
    logic [15:0] hyst_r,    hyst_nxt;
    logic [15:0] ovt_r,     ovt_nxt;
    logic [15:0] temp_r,    temp_nxt;
    logic        fmt_act_r, fmt_act_nxt;
    logic [2:0]  irqst_r,   irqst_nxt;
    logic [2:0]  irqmsk_r,  irqmsk_nxt;
    // Conversion sequencer
    typedef enum logic [1:0] {TSC_IDLE, TSC_CONV, TSC_SHUT} tsc_state_t;
    tsc_state_t  st_r, st_nxt;
    logic [31:0] cc_r, cc_nxt;
    logic        oneshot_r, oneshot_nxt;
    // Alarm state
    logic        alarm_r, alarm_nxt;
    logic        armed_hi_r, armed_hi_nxt;
    // Timeout
    logic [31:0] to_r, to_nxt;
    logic        tout_pulse;
    logic        sda_s;
    logic        tripped;
    logic        fault;
    logic        conv_end;
    logic        wr_en, rd_en;
    logic [15:0] t_code;
    logic signed [16:0] t_s, hyst_s, ovt_s;

    tsc_sync u_sda_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .din     (sda_in),
        .dout    (sda_s)
    );

    // Fresh code and thresholds compared in a common 17-bit scale
    always_comb begin
        t_s    = fmt_act_r ? $signed({t_code[15], t_code}) + 17'sh04000
                           : $signed({t_code[15], t_code});
        hyst_s = fmt_act_r ? $signed({hyst_r[15], hyst_r}) + 17'sh04000
                           : $signed({hyst_r[15], hyst_r});
        ovt_s  = fmt_act_r ? $signed({ovt_r[15], ovt_r}) + 17'sh04000
                           : $signed({ovt_r[15], ovt_r});
    end

    assign conv_end = clk_en && (st_r == TSC_CONV) && (cc_r == 32'h0 || adc_done);

    // Comparator mode: fault is over threshold while alarm low, under hysteresis while high; interrupt mode picks by armed_hi_r
    always_comb begin
        if (!cfg_r[TSC_CFG_INTMD])
            fault = alarm_r ? (t_s < hyst_s) : (t_s > ovt_s);
        else
            fault = armed_hi_r ? (t_s > ovt_s) : (t_s < hyst_s);
    end

    tsc_fault_queue u_fq (
        .pclk      (pclk),
        .presetn   (presetn),
        .clk_en    (clk_en),
        .conv_done (conv_end),
        .fault     (fault),
        .fq_code   ({cfg_r[TSC_CFG_FQ_HI], cfg_r[TSC_CFG_FQ_LO]}),
        .tripped   (tripped)
    );

    assign wr_en  = clk_en && psel && penable && pwrite;
    assign rd_en  = clk_en && psel && penable && !pwrite;
    // Held off while frozen so no write is silently dropped
    assign pready = clk_en;
    assign pslverr = psel && penable && (paddr[1:0] != 2'b00 || paddr > TSC_OFS_IRQMSK);

    // Converted code: extended format stores temperature minus 64 degrees
    always_comb begin
        t_code = fmt_act_r ? adc_temp - TSC_EXT_OFS : adc_temp;
    end

    // Register file, conversion and alarm next state
    always_comb begin
        cfg_nxt      = cfg_r;
        hyst_nxt     = hyst_r;
        ovt_nxt      = ovt_r;
        temp_nxt     = temp_r;
        fmt_act_nxt  = fmt_act_r;
        irqst_nxt    = irqst_r;
        irqmsk_nxt   = irqmsk_r;
        st_nxt       = st_r;
        cc_nxt       = cc_r;
        oneshot_nxt  = oneshot_r;
        alarm_nxt    = alarm_r;
        armed_hi_nxt = armed_hi_r;
        to_nxt       = to_r;
        adc_start    = 1'b0;
        tout_pulse   = 1'b0;
        if (clk_en) begin
            // Clear on write one happens first so a same-cycle set wins
            if (wr_en && paddr == TSC_OFS_IRQST)
                irqst_nxt = irqst_r & ~pwdata[2:0];
            if (wr_en && paddr == TSC_OFS_IRQMSK)
                irqmsk_nxt = pwdata[2:0];
            if (wr_en && paddr == TSC_OFS_HYST)
                hyst_nxt = pwdata[15:0];
            if (wr_en && paddr == TSC_OFS_OVT)
                ovt_nxt = pwdata[15:0];
            if (wr_en && paddr == TSC_OFS_CFG) begin
                cfg_nxt = {oneshot_r, pwdata[6:0]};
                if (pwdata[TSC_CFG_ONESH] && st_r == TSC_SHUT && cfg_r[TSC_CFG_SHDN]) begin
                    oneshot_nxt = 1'b1;
                    cfg_nxt[TSC_CFG_ONESH] = 1'b1;
                end
            end
            // Any register read releases a latched interrupt-mode alarm
            if (rd_en && cfg_r[TSC_CFG_INTMD] && alarm_r) begin
                alarm_nxt    = 1'b0;
                armed_hi_nxt = !armed_hi_r;
            end
            // Sequencer
            unique case (st_r)
                TSC_IDLE: begin
                    if (cfg_r[TSC_CFG_SHDN]) begin
                        st_nxt = TSC_SHUT;
                    end else begin
                        st_nxt    = TSC_CONV;
                        cc_nxt    = CONV_CYC;
                        adc_start = 1'b1;
                    end
                end
                TSC_CONV: begin
                    cc_nxt = (cc_r == 32'h0) ? 32'h0 : cc_r - 32'h1;
                    if (conv_end) begin
                        temp_nxt    = t_code;
                        fmt_act_nxt = cfg_r[TSC_CFG_FMT];
                        irqst_nxt[TSC_IRQ_CONV] = 1'b1;
                        if (oneshot_r) begin
                            oneshot_nxt = 1'b0;
                            cfg_nxt[TSC_CFG_ONESH] = 1'b0;
                            st_nxt = TSC_SHUT;
                        end else begin
                            st_nxt = TSC_IDLE;
                        end
                        if (tripped && fault && !alarm_r) begin
                            alarm_nxt = 1'b1;
                            irqst_nxt[TSC_IRQ_ALARM] = 1'b1;
                        end else if (!cfg_r[TSC_CFG_INTMD] && alarm_r && tripped && fault)
                            alarm_nxt = 1'b0;
                    end
                end
                TSC_SHUT: begin
                    if (cfg_r[TSC_CFG_INTMD]) begin
                        alarm_nxt    = 1'b0;
                        armed_hi_nxt = 1'b1;
                    end
                    if (oneshot_r) begin
                        st_nxt    = TSC_CONV;
                        cc_nxt    = CONV_CYC;
                        adc_start = 1'b1;
                    end else if (!cfg_r[TSC_CFG_SHDN]) begin
                        st_nxt = TSC_IDLE;
                    end
                end
                default: st_nxt = TSC_IDLE;
            endcase
            // Bus timeout watchdog on the data line
            if (cfg_r[TSC_CFG_TODIS] || sda_s) begin
                to_nxt = 32'h0;
            end else if (to_r >= TOUT_CYC) begin
                to_nxt     = 32'h0;
                tout_pulse = 1'b1;
                irqst_nxt[TSC_IRQ_TOUT] = 1'b1;
            end else begin
                to_nxt = to_r + 32'h1;
            end
        end
    end

    // Every register returns to its power-on value on reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r      <= CFG_RST;
            hyst_r     <= TSC_HYST_RST;
            ovt_r      <= TSC_OVT_RST;
            temp_r     <= TSC_TEMP_RST;
            fmt_act_r  <= 1'b0;
            irqst_r    <= 3'h0;
            irqmsk_r   <= 3'h0;
            st_r       <= TSC_IDLE;
            cc_r       <= 32'h0;
            oneshot_r  <= 1'b0;
            alarm_r    <= 1'b0;
            armed_hi_r <= 1'b1;
            to_r       <= 32'h0;
        end else begin
            cfg_r      <= cfg_nxt;
            hyst_r     <= hyst_nxt;
            ovt_r      <= ovt_nxt;
            temp_r     <= temp_nxt;
            fmt_act_r  <= fmt_act_nxt;
            irqst_r    <= irqst_nxt;
            irqmsk_r   <= irqmsk_nxt;
            st_r       <= st_nxt;
            cc_r       <= cc_nxt;
            oneshot_r  <= oneshot_nxt;
            alarm_r    <= alarm_nxt;
            armed_hi_r <= armed_hi_nxt;
            to_r       <= to_nxt;
        end
    end

    // Interface reset pulse, registered to keep it glitch free
    logic bir_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            bir_r <= 1'b1;
        else if (clk_en)
            bir_r <= tout_pulse;
    end
    assign bus_if_reset = bir_r;

    // Read mux; one-shot bit reflects the running conversion
    always_comb begin
        prdata = 32'h0;
        if (psel && !pwrite) begin
            unique case (paddr)
                TSC_OFS_TEMP:   prdata = {16'h0, temp_r};
                TSC_OFS_CFG:    prdata = {24'h0, oneshot_r, cfg_r[6:0]};
                TSC_OFS_HYST:   prdata = {16'h0, hyst_r};
                TSC_OFS_OVT:    prdata = {16'h0, ovt_r};
                TSC_OFS_RAW:    prdata = {30'h0, st_r};
                TSC_OFS_IRQST:  prdata = {29'h0, irqst_r};
                TSC_OFS_IRQMSK: prdata = {29'h0, irqmsk_r};
                default:        prdata = 32'h0;
            endcase
        end
    end

    // Open-drain alarm pin: the asserted level follows the polarity bit
    assign overtemp_alarm_output = 1'b0;
    assign overtemp_alarm_oe_n   = (alarm_r ^ !cfg_r[TSC_CFG_POL]);
    assign irq = |(irqst_r & irqmsk_r);
endmodule : tsc_config_ctrl
`default_nettype wire

// *** bench/tsc_bus_model.sv ***
`default_nettype none
module tsc_bus_model (
    // Data line, pulled up whenever released
    output logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    logic scl;
    // Link clock idles high and only toggles inside a stall
    initial begin
        sda = 1'b1;
        scl = 1'b1;
    end
    // Hold data low for p link periods of 160 ns, then release to the pull-up
    task automatic stall(input int p);
        #2 sda = 1'b0;
        repeat (p) begin
            #80 scl = 1'b0;
            #80 scl = 1'b1;
        end
        sda = 1'b1;
    endtask : stall
endmodule : tsc_bus_model
`default_nettype wire

// *** bench/tsc_config_ctrl_asserts.sv ***
`default_nettype none
module tsc_config_ctrl_asserts
    import tsc_pkg::*;
#(
    parameter bit HAS_RESET_PIN = 1'b1,
    parameter int TOUT_CYC      = TSC_TOUT_CYC,
    parameter int CONV_CYC      = TSC_CONV_CYC_DEF
)(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        clk_en,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Converter, bus line, alarm, interrupt
    input wire logic [15:0] adc_temp,
    input wire logic        adc_done,
    input wire logic        adc_start,
    input wire logic        sda_in,
    input wire logic        bus_if_reset,
    input wire logic        overtemp_alarm_output,
    input wire logic        overtemp_alarm_oe_n,
    input wire logic        irq
);
    logic [7:0]  cfg_r, cfg_nxt;
    logic [15:0] low_r, low_nxt, shd_r, shd_nxt;
    logic [1:0]  alive_r, alive_nxt;
    logic        fired_r, fired_nxt, wseen_r, wseen_nxt, cfg_wr;
    // Shadow config; count time data is low and time spent in shutdown
    always_comb begin
        cfg_wr    = psel && penable && pwrite && pready && paddr == TSC_OFS_CFG;
        cfg_nxt   = cfg_wr ? pwdata[7:0] : cfg_r;
        wseen_nxt = wseen_r | cfg_wr;
        alive_nxt = (alive_r == 2'h3) ? alive_r : alive_r + 2'h1;
        low_nxt   = sda_in ? 16'h0 : low_r + 16'(low_r != 16'hffff);
        fired_nxt = !sda_in && (fired_r || bus_if_reset);
        shd_nxt   = cfg_wr ? 16'h0 : shd_r + 16'(cfg_r[TSC_CFG_SHDN] && shd_r != 16'hffff);
    end
    // Registers; the reset-time bus reset pulse is masked by alive_r
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r   <= HAS_RESET_PIN ? TSC_CFG_RST_PIN : TSC_CFG_RST_NOPIN;
            {wseen_r, alive_r, low_r, fired_r, shd_r} <= '0;
        end else begin
            cfg_r   <= cfg_nxt;
            {wseen_r, alive_r, low_r, fired_r, shd_r} <=
                {wseen_nxt, alive_nxt, low_nxt, fired_nxt, shd_nxt};
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_DRIVE_ZERO: assert property (overtemp_alarm_output == 1'b0)
        else $error("alarm pin drive value not zero");
    AST_TOUT_OFF: assert property (bus_if_reset && alive_r == 2'h3 |-> !cfg_r[6])
        else $error("bus reset while timeout disabled");
    AST_TOUT_LONG: assert property (bus_if_reset && alive_r == 2'h3 |-> low_r > TOUT_CYC)
        else $error("bus reset before data low long enough");
    AST_TOUT_FIRE: assert property (!cfg_r[6] && low_r == TOUT_CYC + 8 |-> fired_r)
        else $error("no bus reset after long low data");
    AST_START_ONE: assert property ($rose(adc_start) |=> !adc_start)
        else $error("conversion start longer than one cycle");
    AST_SHDN_QUIET: assert property (cfg_r[0] && shd_r > CONV_CYC + 2 |-> !adc_start)
        else $error("conversion started in shutdown");
    AST_ONESHOT_GO: assert property (cfg_wr && pwdata[7] && pwdata[0] && cfg_r[0]
        && shd_r > CONV_CYC + 2 |-> ##[1:4] adc_start) else $error("one-shot did not start");
    AST_WAKE_GO: assert property (cfg_wr && !pwdata[0] && cfg_r[0]
        && shd_r > CONV_CYC + 2 |-> ##[1:4] adc_start) else $error("wake did not start");
    AST_CFG_DEFAULT: assert property (psel && penable && !pwrite && paddr == TSC_OFS_CFG
        && !wseen_r |-> prdata[7:0] == (HAS_RESET_PIN ? TSC_CFG_RST_PIN : TSC_CFG_RST_NOPIN))
        else $error("config default wrong");
    CV_TOUT: cover property (bus_if_reset && alive_r == 2'h3);
    CV_ONESHOT: cover property (cfg_wr && pwdata[7] && cfg_r[0]);
    CV_ALARM: cover property (irq && !overtemp_alarm_oe_n);
endmodule : tsc_config_ctrl_asserts
bind tsc_config_ctrl tsc_config_ctrl_asserts #(.HAS_RESET_PIN(HAS_RESET_PIN),
    .TOUT_CYC(TOUT_CYC), .CONV_CYC(CONV_CYC)) u_tsc_config_ctrl_asserts (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .adc_temp(adc_temp), .adc_done(adc_done), .adc_start(adc_start),
    .sda_in(sda_in), .bus_if_reset(bus_if_reset), .overtemp_alarm_output(overtemp_alarm_output),
    .overtemp_alarm_oe_n(overtemp_alarm_oe_n), .irq(irq));
`default_nettype wire

// *** bench/tb_tsc_config_ctrl.sv ***
`default_nettype none
module tb_tsc_config_ctrl;
    import tsc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TC = 100;
    localparam int CC = 8;
    typedef struct {logic w; logic [7:0] a; logic [31:0] d, e; logic er;} tsc_row_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] adc_temp;
    logic        adc_start, sda, bir, alo, aoe, irq;
    int          fail_count, checks_done, n;
    int          nf[4] = '{1, 2, 4, 6};
    tsc_row_t    rows[6] = '{'{0, TSC_OFS_TEMP, 0, 0, 0}, '{0, TSC_OFS_CFG, 0, 32'h40, 0},
        '{0, TSC_OFS_HYST, 0, 32'h4b00, 0}, '{0, TSC_OFS_OVT, 0, 32'h5000, 0},
        '{1, TSC_OFS_HYST, 32'h4800, 32'h4800, 0}, '{0, 8'h1c, 0, 0, 1}};
    // Short timeout and conversion counts keep the run brief
    tsc_config_ctrl #(.TOUT_CYC(TC), .CONV_CYC(CC)) u_tsc_config_ctrl (
        .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .adc_temp(adc_temp), .adc_done(1'b0), .adc_start(adc_start),
        .sda_in(sda), .bus_if_reset(bir), .overtemp_alarm_output(alo),
        .overtemp_alarm_oe_n(aoe), .irq(irq));
    tsc_bus_model u_tsc_bus_model (.sda(sda));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // One APB transfer; read data and error taken at the pready edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        fail_count += int'(pready !== 1'b1); // A wait that runs out is a mismatch
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
        #1;
    endtask : apb
    // Wait for k conversion starts, each bounded
    task automatic wst(input int k);
        repeat (k) begin
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while (adc_start !== 1'b1 && n < 40);
            chk("conversion start", 1, 32'(n < 40));
        end
    endtask : wst
    task automatic starts(input int m);
        n = 0;
        repeat (m) begin
            @(posedge pclk);
            n += int'(adc_start === 1'b1);
        end
    endtask : starts
    // Stall the data line for p link periods and count bus reset pulses
    task automatic tout(input int p, input int e);
        int c;
        c = 0;
        fork
            u_tsc_bus_model.stall(p);
            repeat (p * 16 + 10) begin
                @(posedge pclk);
                c += int'(bir === 1'b1);
            end
        join
        chk("bus reset pulses", e, c);
    endtask : tout
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish
    // Hang guard, well beyond the expected run of under two thousand cycles
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        tally_and_finish();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, adc_temp} = '0;
        fail_count = 0;
        checks_done = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (rows[i].w) apb(1'b0, rows[i].a, 32'h0);
            chk("read data", rows[i].e, rd);
            chk("slave error", 32'(rows[i].er), 32'(er));
        end
        apb(1'b1, TSC_OFS_IRQMSK, 32'h2);
        // Alarm only on the n-th consecutive hot conversion, for every queue code
        for (int q = 0; q < 4; q++) begin
            adc_temp <= 16'h1900;
            wst(8);
            apb(1'b1, TSC_OFS_CFG, 32'(q) << TSC_CFG_FQ_LO);
            wst(1);
            adc_temp <= 16'h5100;
            for (int k = 1; k <= nf[q]; k++) begin
                wst(1);
                repeat (4) @(posedge pclk);
                chk("alarm pin", 32'(k != nf[q]), 32'(aoe));
            end
        end
        // Interrupt follows status and mask; write one clears
        chk("irq", 1, 32'(irq));
        apb(1'b1, TSC_OFS_IRQMSK, 32'h0);
        chk("irq", 0, 32'(irq));
        apb(1'b1, TSC_OFS_IRQMSK, 32'h2);
        chk("irq", 1, 32'(irq));
        apb(1'b1, TSC_OFS_IRQST, 32'h2);
        chk("irq", 0, 32'(irq));
        apb(1'b1, TSC_OFS_CFG, 32'h1c);
        repeat (2) @(posedge pclk);
        chk("alarm pin", 1, 32'(aoe));
        // Latched mode: a read releases, the opposite crossing asserts again
        apb(1'b1, TSC_OFS_CFG, 32'h2);
        apb(1'b0, TSC_OFS_TEMP, 32'h0);
        chk("alarm pin", 1, 32'(aoe));
        adc_temp <= 16'h1900;
        wst(2);
        chk("alarm pin", 0, 32'(aoe));
        apb(1'b0, TSC_OFS_TEMP, 32'h0);
        chk("alarm pin", 1, 32'(aoe));
        // Format switch shows only after the following conversion
        adc_temp <= 16'h1900;
        wst(2);
        apb(1'b1, TSC_OFS_CFG, 32'h20);
        wst(1);
        apb(1'b0, TSC_OFS_TEMP, 32'h0);
        chk("temperature", 32'h1900, rd);
        wst(1);
        apb(1'b0, TSC_OFS_TEMP, 32'h0);
        chk("temperature", 32'hd900, rd);
        apb(1'b1, TSC_OFS_CFG, 32'h80);
        apb(1'b0, TSC_OFS_CFG, 32'h0);
        chk("config", 32'h0, rd);
        apb(1'b1, TSC_OFS_CFG, 32'h1);
        repeat (CC + 3) @(posedge pclk);
        starts(40);
        chk("starts in shutdown", 0, n);
        apb(1'b1, TSC_OFS_IRQST, 32'h7);
        apb(1'b1, TSC_OFS_CFG, 32'h81);
        apb(1'b0, TSC_OFS_CFG, 32'h0);
        chk("config", 32'h81, rd);
        for (int i = 0; i < 10 && rd[7] === 1'b1; i++) apb(1'b0, TSC_OFS_CFG, 32'h0);
        chk("config", 32'h1, rd);
        apb(1'b0, TSC_OFS_IRQST, 32'h0);
        chk("conversion done", 32'h1, rd & 32'h1);
        starts(40);
        chk("starts after one-shot", 0, n);
        apb(1'b0, TSC_OFS_RAW, 32'h0);
        chk("state", 32'h2, rd);
        apb(1'b1, TSC_OFS_CFG, 32'h0);
        wst(1);
        tout(5, 0);
        tout(10, 1);
        apb(1'b1, TSC_OFS_CFG, 32'h40);
        tout(10, 0);
        // Reset in mid-run restores defaults
        apb(1'b1, TSC_OFS_HYST, 32'h1111);
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        chk("bus reset", 1, 32'(bir));
        presetn <= 1'b1;
        apb(1'b0, TSC_OFS_HYST, 32'h0);
        chk("hysteresis", 32'(TSC_HYST_RST), rd);
        apb(1'b0, TSC_OFS_CFG, 32'h0);
        chk("config", 32'(TSC_CFG_RST_PIN), rd);
        tally_and_finish();
    end
endmodule : tb_tsc_config_ctrl
`default_nettype wire
